/* File: pkg/srd_pkg.sv */
// Constants shared by the soft RISC decode and execute stage.
package srd_pkg;
	localparam int unsigned DW = 32;
	// Field positions; architectural bit k is vector bit 31-k.
	localparam int unsigned OPC_HI = 31;
	localparam int unsigned OPC_LO = 26;
	localparam int unsigned RD_HI = 25;
	localparam int unsigned RD_LO = 21;
	localparam int unsigned RA_HI = 20;
	localparam int unsigned RA_LO = 16;
	localparam int unsigned RB_HI = 15;
	localparam int unsigned RB_LO = 11;
	localparam int unsigned IMM_HI = 15;
	localparam int unsigned FN_HI = 10;
	localparam int unsigned IMM14_HI = 13;
	localparam int unsigned SEL_HI = 2;
	localparam int unsigned AMT_HI = 4;
	// Opcode control bits.
	localparam int unsigned BIT_TYPEB = 29;
	localparam int unsigned BIT_KEEP = 28;
	localparam int unsigned BIT_CUSE = 27;
	localparam int unsigned BIT_SUB = 26;
	localparam int unsigned BIT_SWR = 15;
	localparam int unsigned BIT_SNB = 14;
	localparam int unsigned BIT_SCTL = 13;
	localparam int unsigned BIT_SH_LEFT = 10;
	localparam int unsigned BIT_SH_ARITH = 9;
	localparam int unsigned BIT_SPR_A = 15;
	localparam int unsigned BIT_SPR_B = 14;
	localparam int unsigned BIT_DLY = 20;
	// Machine status bit positions.
	localparam int unsigned MSW_CARRY = 2;
	localparam int unsigned MSW_STREAM = 4;
	localparam int unsigned MSW_COPY = 31;
	localparam logic [31:0] MSW_RESET = 32'h0000_0000;
	// Opcodes.
	localparam logic [1:0] OPG_ARITH = 2'h0;
	localparam logic [5:0] OP_MUL = 6'h10;
	localparam logic [5:0] OP_BSH = 6'h11;
	localparam logic [5:0] OP_DIV = 6'h12;
	localparam logic [5:0] OP_MULI = 6'h18;
	localparam logic [5:0] OP_BSHI = 6'h19;
	localparam logic [5:0] OP_STREAM = 6'h1B;
	localparam logic [5:0] OP_OR = 6'h20;
	localparam logic [5:0] OP_AND = 6'h21;
	localparam logic [5:0] OP_XOR = 6'h22;
	localparam logic [5:0] OP_AND_WITH_INVERTED = 6'h23;
	localparam logic [5:0] OP_MISC = 6'h24;
	localparam logic [5:0] OP_SPR = 6'h25;
	localparam logic [5:0] OP_BRR = 6'h26;
	localparam logic [5:0] OP_PREFIX = 6'h2C;
	localparam logic [5:0] OP_RSUBK = 6'h05;
	// Function codes.
	localparam logic [10:0] FN_CMP = 11'h001;
	localparam logic [10:0] FN_COMPARE_UNSIGNED = 11'h003;
	localparam logic [10:0] FN_DIVU = 11'h001;
	localparam logic [6:0] FN_SRA = 7'h01;
	localparam logic [6:0] FN_SRC = 7'h21;
	localparam logic [6:0] FN_SRL = 7'h41;
	localparam logic [6:0] FN_SIGN_EXTEND_BYTE = 7'h60;
	localparam logic [6:0] FN_SIGN_EXTEND_HALF = 7'h61;
	localparam logic [7:0] FN_ICW = 8'h68;
	localparam logic [7:0] FN_DCW = 8'h64;
	localparam logic [4:0] RA_SET = 5'h00;
	localparam logic [4:0] RA_CLR = 5'h01;
	localparam logic [4:0] RA_BR = 5'h00;
	localparam logic [4:0] RA_BRD = 5'h10;
	localparam logic [2:0] SEL_PC = 3'h0;
	localparam logic [2:0] SEL_MSW = 3'h1;
	localparam logic [2:0] SEL_EAR = 3'h3;
	localparam logic [2:0] SEL_ESR = 3'h5;
endpackage

/* File: src/srd_decode_exec.sv */
// Decode and execute stage of the soft RISC core.
`timescale 1ns/100ps
// Operation
// - Every instruction is a 32-bit word of register or immediate format.
// - Register format: opcode, destination, source a, source b, function field.
// - Immediate format carries 16 bits, widened to 32 after a prefix.
// - Big-endian with bit 0 as most significant bit.
// - An unprefixed 16-bit immediate is sign-extended to 32 bits.
// - Register add and reverse subtract, carry forms add the carry flag.
// - Same add and reverse-subtract set with immediate instead of b.
// - Signed and unsigned compare compute b minus a, top bit set when a exceeds b.
// - Multiply a by b, or a by sign-extended immediate.
// - Barrel shift right logical, right arithmetic or left, register or immediate.
// - Divide b by a, signed or unsigned by function field.
// - Stream port get/put with write, non-blocking and control bits.
// - Non-blocking forms set carry; reads store the control flag, inverted when the control bit is set, in status.
// - OR, AND, XOR and AND-with-inverted-b of two registers.
// - Single-bit right shifts fill with sign, carry or zero; carry from bit 31.
// - Sign-extend low byte or low half word of source a.
// - Cache line writes send a as tag and b as data.
// - Move from special registers by selector; move to special writes the status word only.
// - Status set and clear return old value then modify with 14-bit immediate.
// - Register-relative branch adds b to program counter, delayed form too.
// - Register zero reads zero and writes to it are dropped.
// - Prefix opcode supplies upper 16 immediate bits for the next instruction.
// - Status write by move-to-special lands a cycle later; a status set or clear then replaces it, carry or stream bit updates then override; bit 0 ignored.
module srd_decode_exec (
	input  wire logic        clock,                 // Core clock, 250 MHz.
	input  wire logic        rst,                   // Synchronous reset, active high.
	input  wire logic        instr_valid,           // Instruction word is present.
	input  wire logic [31:0] instr,                 // Instruction word.
	output logic             stall,                 // Instruction held by a blocking stream op.
	output logic [4:0]       ra_addr,               // Register file read address a.
	output logic [4:0]       rb_addr,               // Register file read address b.
	input  wire logic [31:0] ra_data,               // Register file read data a.
	input  wire logic [31:0] rb_data,               // Register file read data b.
	input  wire logic [31:0] pc,                    // Address of the current instruction.
	input  wire logic [31:0] exception_address_reg, // Exception address value.
	input  wire logic [31:0] exception_status_reg,  // Exception status value.
	input  wire logic        stream_in_has_data,    // Input stream holds a word.
	input  wire logic        stream_in_ctrl_flag,   // Input word is a control word.
	input  wire logic [31:0] stream_in_data,        // Input stream word.
	input  wire logic        stream_out_full,       // Output stream cannot take a word.
	output logic             wr_en,                 // Register file write strobe.
	output logic [4:0]       wr_addr,               // Register file write address.
	output logic [31:0]      wr_data,               // Register file write data.
	output logic             redirect,              // Fetch must jump, one-cycle pulse.
	output logic [31:0]      redirect_target,       // Jump target.
	output logic             stream_get,            // Input word consumed, pulse.
	output logic             stream_put,            // Output word written, pulse.
	output logic [2:0]       stream_port_n,         // Stream port of the last get or put.
	output logic             stream_ctrl,           // Put word is a control word.
	output logic [31:0]      stream_out_data,       // Put word.
	output logic             icache_line_write,     // Instruction cache write pulse.
	output logic             dcache_line_write,     // Data cache write pulse.
	output logic [31:0]      cache_tag,             // Cache tag value.
	output logic [31:0]      cache_data,            // Cache data value.
	output logic [31:0]      machine_status_word,   // Status, carry copied into bit 0.
	output logic             imm_pending            // A prefix is waiting for its user.
);
	typedef struct packed {
		logic        wr_en;
		logic [4:0]  wr_addr;
		logic [31:0] wr_data;
		logic        redirect;
		logic [31:0] redirect_target;
		logic        get;
		logic        put;
		logic [2:0]  port;
		logic        sctl;
		logic [31:0] sdata;
		logic        icw;
		logic        dcw;
		logic [31:0] tag;
		logic [31:0] cdata;
		logic [31:0] msw;
		logic        msw_pend;
		logic [31:0] msw_new;
		logic        imm_vld;
		logic [15:0] imm_hi;
		logic        dly_pend;
		logic [31:0] dly_tgt;
	} srd_state_s;

	srd_state_s s_q, s_d;
	logic [5:0]  opc;
	logic [4:0]  rd;
	logic [10:0] fn;
	logic [31:0] a, b, imm32, opb, shifted;
	logic        typeb, carry, cin, fire, is_stream, blk, use_imm;
	logic [32:0] sum;

	// Field split; vector bit 31 is architectural bit 0.
	assign opc = instr[srd_pkg::OPC_HI:srd_pkg::OPC_LO];
	assign rd = instr[srd_pkg::RD_HI:srd_pkg::RD_LO];
	assign ra_addr = instr[srd_pkg::RA_HI:srd_pkg::RA_LO];
	assign rb_addr = instr[srd_pkg::RB_HI:srd_pkg::RB_LO];
	assign fn = instr[srd_pkg::FN_HI:0];
	assign typeb = instr[srd_pkg::BIT_TYPEB];

	// Register zero is forced to zero here so a stale file entry cannot leak.
	assign a = (ra_addr == 5'h00) ? 32'h0000_0000 : ra_data;
	assign b = (rb_addr == 5'h00) ? 32'h0000_0000 : rb_data;

	// Immediate: prefixed upper half, else sign extension.
	assign imm32 = s_q.imm_vld ? {s_q.imm_hi, instr[srd_pkg::IMM_HI:0]}
		: {{16{instr[srd_pkg::IMM_HI]}}, instr[srd_pkg::IMM_HI:0]};
	assign use_imm = typeb && (opc != srd_pkg::OP_BSHI);
	assign opb = use_imm ? imm32 : b;

	// Adder for add, reverse subtract and compare.
	assign carry = s_q.msw[srd_pkg::MSW_CARRY];
	assign cin = instr[srd_pkg::BIT_CUSE] ? carry : instr[srd_pkg::BIT_SUB];
	assign sum = {1'b0, opb} + {1'b0, instr[srd_pkg::BIT_SUB] ? ~a : a} + {32'h0000_0000, cin};

	// Barrel shift amount from b or from the low five immediate bits.
	always_comb begin
		logic [4:0] amt;
		amt = (opc == srd_pkg::OP_BSHI) ? instr[srd_pkg::AMT_HI:0] : b[4:0];
		if (instr[srd_pkg::BIT_SH_LEFT]) begin
			shifted = a << amt;
		end else if (instr[srd_pkg::BIT_SH_ARITH]) begin
			shifted = 32'($signed(a) >>> amt);
		end else begin
			shifted = a >> amt;
		end
	end

	// Blocking stream ops hold the stage until the port can move a word.
	assign is_stream = (opc == srd_pkg::OP_STREAM);
	assign blk = instr[srd_pkg::BIT_SWR] ? stream_out_full : !stream_in_has_data;
	assign stall = instr_valid && is_stream && !instr[srd_pkg::BIT_SNB] && blk;
	assign fire = instr_valid && !stall;

	// Next-state logic: one instruction retires per fired cycle.
	always_comb begin
		logic [31:0] res;
		logic        we;
		s_d = s_q;
		res = 32'h0000_0000;
		we = 1'b1;
		s_d.wr_en = 1'b0;
		s_d.redirect = 1'b0;
		s_d.get = 1'b0;
		s_d.put = 1'b0;
		s_d.icw = 1'b0;
		s_d.dcw = 1'b0;
		// The staged status write lands one cycle late; a status set or clear replaces it, and carry or stream bit updates override; bit 0 is never stored.
		if (s_q.msw_pend) begin
			s_d.msw = {1'b0, s_q.msw_new[30:0]};
			s_d.msw_pend = 1'b0;
		end
		if (fire) begin
			s_d.imm_vld = 1'b0;
			if (opc[5:4] == srd_pkg::OPG_ARITH) begin
				res = sum[31:0];
				if (opc == srd_pkg::OP_RSUBK && (fn == srd_pkg::FN_CMP || fn == srd_pkg::FN_COMPARE_UNSIGNED)) begin
					// Top bit tells whether a exceeds b, as signed or unsigned.
					res[31] = (fn == srd_pkg::FN_CMP) ? ($signed(a) > $signed(b)) : (a > b);
				end
				if (!instr[srd_pkg::BIT_KEEP]) begin
					s_d.msw[srd_pkg::MSW_CARRY] = sum[32];
				end
			end else begin
				case (opc)
					srd_pkg::OP_MUL, srd_pkg::OP_MULI: res = 32'(a * opb);
					srd_pkg::OP_BSH, srd_pkg::OP_BSHI: res = shifted;
					srd_pkg::OP_DIV: begin
						// Division by zero returns zero rather than a garbage quotient.
						if (a == 32'h0000_0000) begin
							res = 32'h0000_0000;
						end else if (fn == srd_pkg::FN_DIVU) begin
							res = b / a;
						end else begin
							res = 32'($signed(b) / $signed(a));
						end
					end
					srd_pkg::OP_STREAM: begin
						s_d.port = instr[srd_pkg::SEL_HI:0];
						s_d.sctl = instr[srd_pkg::BIT_SCTL];
						if (instr[srd_pkg::BIT_SWR]) begin
							we = 1'b0;
							s_d.put = !stream_out_full;
							s_d.sdata = a;
							if (instr[srd_pkg::BIT_SNB]) begin
								s_d.msw[srd_pkg::MSW_CARRY] = stream_out_full;
							end
						end else begin
							res = stream_in_data;
							s_d.get = stream_in_has_data;
							s_d.msw[srd_pkg::MSW_STREAM] = instr[srd_pkg::BIT_SCTL]
								? !stream_in_ctrl_flag : stream_in_ctrl_flag;
							if (instr[srd_pkg::BIT_SNB]) begin
								s_d.msw[srd_pkg::MSW_CARRY] = !stream_in_has_data;
							end
						end
					end
					srd_pkg::OP_OR: res = a | b;
					srd_pkg::OP_AND: res = a & b;
					srd_pkg::OP_XOR: res = a ^ b;
					srd_pkg::OP_AND_WITH_INVERTED: res = a & ~b;
					srd_pkg::OP_MISC: begin
						case (fn[6:0])
							srd_pkg::FN_SRA: res = {a[31], a[31:1]};
							srd_pkg::FN_SRC: res = {carry, a[31:1]};
							srd_pkg::FN_SRL: res = {1'b0, a[31:1]};
							srd_pkg::FN_SIGN_EXTEND_BYTE: res = {{24{a[7]}}, a[7:0]};
							srd_pkg::FN_SIGN_EXTEND_HALF: res = {{16{a[15]}}, a[15:0]};
							default: we = 1'b0;
						endcase
						// Architectural bit 31 of a is vector bit 0.
						if (fn[6:0] == srd_pkg::FN_SRA || fn[6:0] == srd_pkg::FN_SRC
							|| fn[6:0] == srd_pkg::FN_SRL) begin
							s_d.msw[srd_pkg::MSW_CARRY] = a[0];
						end
						if (fn[7:0] == srd_pkg::FN_ICW || fn[7:0] == srd_pkg::FN_DCW) begin
							s_d.icw = (fn[7:0] == srd_pkg::FN_ICW);
							s_d.dcw = (fn[7:0] == srd_pkg::FN_DCW);
							s_d.tag = a;
							s_d.cdata = b;
						end
					end
					srd_pkg::OP_SPR: begin
						if (instr[srd_pkg::BIT_SPR_A] && instr[srd_pkg::BIT_SPR_B]) begin
							// Move to special: only the status word is writable here.
							we = 1'b0;
							if (instr[srd_pkg::SEL_HI:0] == srd_pkg::SEL_MSW) begin
								s_d.msw_pend = 1'b1;
								s_d.msw_new = a;
							end
						end else if (instr[srd_pkg::BIT_SPR_A]) begin
							case (instr[srd_pkg::SEL_HI:0])
								srd_pkg::SEL_PC: res = pc;
								srd_pkg::SEL_MSW: res = machine_status_word;
								srd_pkg::SEL_EAR: res = exception_address_reg;
								srd_pkg::SEL_ESR: res = exception_status_reg;
								default: res = 32'h0000_0000;
							endcase
						end else begin
							// Old value returned; set ORs, clear masks the immediate.
							res = machine_status_word;
							if (ra_addr == srd_pkg::RA_SET) begin
								s_d.msw = s_q.msw | {18'h00000, instr[srd_pkg::IMM14_HI:0]};
							end else if (ra_addr == srd_pkg::RA_CLR) begin
								s_d.msw = s_q.msw & ~{18'h00000, instr[srd_pkg::IMM14_HI:0]};
							end else begin
								we = 1'b0;
							end
						end
					end
					srd_pkg::OP_BRR: begin
						we = 1'b0;
						if (ra_addr == srd_pkg::RA_BR) begin
							s_d.redirect = 1'b1;
							s_d.redirect_target = pc + b;
						end else if (ra_addr == srd_pkg::RA_BRD) begin
							s_d.dly_pend = 1'b1;
							s_d.dly_tgt = pc + b;
						end
					end
					srd_pkg::OP_PREFIX: begin
						we = 1'b0;
						s_d.imm_vld = 1'b1;
						s_d.imm_hi = instr[srd_pkg::IMM_HI:0];
					end
					default: we = 1'b0;
				endcase
			end
			// The slot instruction has now run, so the held jump goes out.
			if (s_q.dly_pend) begin
				s_d.dly_pend = 1'b0;
				s_d.redirect = 1'b1;
				s_d.redirect_target = s_q.dly_tgt;
			end
			s_d.wr_en = we && (rd != 5'h00);
			s_d.wr_addr = rd;
			s_d.wr_data = res;
		end
	end

	// State register; control state clears, data words clear too for clean outputs.
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.msw <= srd_pkg::MSW_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign wr_en = s_q.wr_en;
	assign wr_addr = s_q.wr_addr;
	assign wr_data = s_q.wr_data;
	assign redirect = s_q.redirect;
	assign redirect_target = s_q.redirect_target;
	assign stream_get = s_q.get;
	assign stream_put = s_q.put;
	assign stream_port_n = s_q.port;
	assign stream_ctrl = s_q.sctl;
	assign stream_out_data = s_q.sdata;
	assign icache_line_write = s_q.icw;
	assign dcache_line_write = s_q.dcw;
	assign cache_tag = s_q.tag;
	assign cache_data = s_q.cdata;
	assign imm_pending = s_q.imm_vld;
	// Carry is mirrored into architectural bit 0 on every read.
	assign machine_status_word = {s_q.msw[srd_pkg::MSW_CARRY], s_q.msw[30:0]};

	sequence s_mts;
		fire && opc == srd_pkg::OP_SPR && instr[srd_pkg::BIT_SPR_A] && instr[srd_pkg::BIT_SPR_B]
			&& instr[srd_pkg::SEL_HI:0] == srd_pkg::SEL_MSW;
	endsequence
	sequence s_brd;
		fire && opc == srd_pkg::OP_BRR && ra_addr == srd_pkg::RA_BRD && !s_q.dly_pend;
	endsequence

	a_r0_no_write: assert property (@(posedge clock) disable iff (rst)
		wr_en |-> wr_addr != 5'h00) else $error("write to register zero");
	a_mts_one_late: assert property (@(posedge clock) disable iff (rst)
		s_mts ##1 !fire |=> machine_status_word[30:0] == $past(a[30:0], 2))
		else $error("status write not applied one cycle late");
	a_get_blocks: assert property (@(posedge clock) disable iff (rst)
		instr_valid && is_stream && !instr[srd_pkg::BIT_SWR] && !instr[srd_pkg::BIT_SNB]
		&& !stream_in_has_data |-> stall && !fire) else $error("blocking get did not stall");
	a_nget_carry: assert property (@(posedge clock) disable iff (rst)
		fire && is_stream && !instr[srd_pkg::BIT_SWR] && instr[srd_pkg::BIT_SNB] |=>
		machine_status_word[srd_pkg::MSW_CARRY] == !$past(stream_in_has_data))
		else $error("non-blocking get carry wrong");
	a_add_result: assert property (@(posedge clock) disable iff (rst)
		fire && opc == 6'h00 && rd != 5'h00 |=> wr_en && wr_data == $past(a + b))
		else $error("register add result wrong");
	a_prefix_imm: assert property (@(posedge clock) disable iff (rst)
		fire && opc == 6'h0C && s_q.imm_vld && rd != 5'h00 |=>
		wr_data == $past({s_q.imm_hi, instr[15:0]} + a)) else $error("prefix not used");
	a_delay_slot: assert property (@(posedge clock) disable iff (rst)
		s_brd |=> !redirect && s_q.dly_pend)
		else $error("delayed branch redirected early");
	a_sext_byte: assert property (@(posedge clock) disable iff (rst)
		fire && opc == srd_pkg::OP_MISC && fn[6:0] == srd_pkg::FN_SIGN_EXTEND_BYTE && rd != 5'h00 |=>
		wr_data == {{24{$past(a[7])}}, $past(a[7:0])}) else $error("byte sign extend wrong");
	a_nput_carry: assert property (@(posedge clock) disable iff (rst)
		fire && is_stream && instr[srd_pkg::BIT_SWR] && instr[srd_pkg::BIT_SNB] |=>
		machine_status_word[srd_pkg::MSW_CARRY] == $past(stream_out_full) && !wr_en)
		else $error("non-blocking put carry wrong");
endmodule // srd_decode_exec

/* File: tb/srd_partner.sv */
// Register file and forwarding model standing behind the decode stage.
`timescale 1ns/100ps
module srd_partner (
	input  wire logic        clock,   // Core clock.
	input  wire logic [4:0]  ra_addr, // Read address a.
	input  wire logic [4:0]  rb_addr, // Read address b.
	output logic      [31:0] ra_data, // Read data a.
	output logic      [31:0] rb_data, // Read data b.
	input  wire logic        wr_en,   // Write strobe.
	input  wire logic [4:0]  wr_addr, // Write address.
	input  wire logic [31:0] wr_data  // Write data.
);
	logic [31:0] regs_q [32];

	// Storage starts cleared as after configuration; core reset leaves it alone.
	initial begin
		for (int i = 0; i < 32; i++) begin
			regs_q[i] = 32'h0000_0000;
		end
	end

	// A write still in flight is forwarded, so back-to-back users see it.
	// Written out in place: a function call would not wake on a file update.
	assign ra_data = (ra_addr == 5'h00) ? 32'h0000_0000
		: (wr_en && wr_addr == ra_addr) ? wr_data : regs_q[ra_addr];
	assign rb_data = (rb_addr == 5'h00) ? 32'h0000_0000
		: (wr_en && wr_addr == rb_addr) ? wr_data : regs_q[rb_addr];

	// Register zero keeps no value.
	always @(posedge clock) begin
		if (wr_en && wr_addr != 5'h00) begin
			regs_q[wr_addr] <= wr_data;
		end
	end
endmodule // srd_partner

/* File: tb/test_srd_decode_exec.sv */
// Self-checking testbench for the soft RISC decode and execute stage.
`timescale 1ns/100ps
module test_srd_decode_exec;
	logic        clock = 1'b0, rst = 1'b1, instr_valid = 1'b0;
	logic [31:0] instr = 32'h0, pc = 32'h0, stream_in_data = 32'h0;
	logic [31:0] exception_address_reg = 32'h0000_0A00;
	logic [31:0] exception_status_reg  = 32'h0000_00E0;
	logic        stream_in_has_data = 1'b0, stream_in_ctrl_flag = 1'b0, stream_out_full = 1'b0;
	logic        stall, wr_en, redirect, stream_get, stream_put, stream_ctrl;
	logic        icache_line_write, dcache_line_write, imm_pending;
	logic [4:0]  ra_addr, rb_addr, wr_addr;
	logic [2:0]  stream_port_n;
	logic [31:0] ra_data, rb_data, wr_data, redirect_target, stream_out_data;
	logic [31:0] cache_tag, cache_data, machine_status_word;
	logic [31:0] rg [32];
	int          n_mismatch = 0;
	int          total_checks = 0;

	// The register file model and the stage share every port name.
	srd_partner     partner (.*);
	srd_decode_exec dut (.*);

	// Core clock, 4 ns period.
	always #2 clock = ~clock;

	function automatic logic [31:0] fa(logic [5:0] op, logic [4:0] d, a, b, logic [10:0] fn);
		return {op, d, a, b, fn};
	endfunction
	function automatic logic [31:0] fb(logic [5:0] op, logic [4:0] d, a, logic [15:0] im);
		return {op, d, a, im};
	endfunction

	// Compare and count; an unknown never passes.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask
	// Drop valid first, or the held word would fire again on the next edge.
	task automatic idle(input int n);
		instr_valid = 1'b0;
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Present one word, ride out a stall under a bound, then inspect the write port.
	task automatic ex(input logic [31:0] w, input logic we, input logic [4:0] wa,
			input logic [31:0] wd);
		int n;
		n = 0;
		instr = w;
		instr_valid = 1'b1;
		#1;
		while (stall !== 1'b0 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 20) begin
			n_mismatch++;
			finish_test();
		end
		@(posedge clock);
		#1;
		chkb("wr_en", we, wr_en);
		if (we) begin
			chk("wr_addr", {27'h0, wa}, {27'h0, wr_addr});
			chk("wr_data", wd, wr_data);
			rg[wa] = wd;
		end
	endtask
	task automatic carry(input logic c);
		chkb("carry", c, machine_status_word[srd_pkg::MSW_CARRY]);
		chkb("carry_copy", c, machine_status_word[srd_pkg::MSW_COPY]);
	endtask

	// A hang is cut short here and reported like any other mismatch.
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		chk("status_reset", 32'h0, machine_status_word);
		ex(fb(6'h08, 5'd1, 5'd0, 16'hFFF0), 1'b1, 5'd1, 32'hFFFF_FFF0);
		ex(fb(6'h2C, 5'd0, 5'd0, 16'h1234), 1'b0, 5'd0, 32'h0);
		chkb("imm_pending", 1'b1, imm_pending);
		ex(fb(6'h0C, 5'd2, 5'd0, 16'h5678), 1'b1, 5'd2, 32'h1234_5678);
		ex(fb(6'h08, 5'd4, 5'd0, 16'h0004), 1'b1, 5'd4, 32'h0000_0004);
		ex(fb(6'h08, 5'd6, 5'd0, 16'h0003), 1'b1, 5'd6, 32'h0000_0003);
		ex(fb(6'h2C, 5'd0, 5'd0, 16'h0000), 1'b0, 5'd0, 32'h0);
		ex(fb(6'h08, 5'd7, 5'd0, 16'h8080), 1'b1, 5'd7, 32'h0000_8080);
		done("immediates");
		ex(fa(6'h00, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] + rg[1]);
		ex(fa(6'h01, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] - rg[1]);
		ex(fa(6'h05, 5'd3, 5'd1, 5'd2, 11'h001), 1'b1, 5'd3, 32'h1234_5688);
		ex(fa(6'h05, 5'd3, 5'd1, 5'd2, 11'h003), 1'b1, 5'd3, 32'h9234_5688);
		ex(fb(6'h09, 5'd3, 5'd1, 16'h0010), 1'b1, 5'd3, 32'h0000_0020);
		ex(fa(6'h24, 5'd5, 5'd6, 5'd0, 11'h041), 1'b1, 5'd5, 32'h0000_0001);
		carry(1'b1);
		ex(fa(6'h24, 5'd5, 5'd6, 5'd0, 11'h021), 1'b1, 5'd5, 32'h8000_0001);
		ex(fa(6'h06, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] + rg[1] + 1);
		ex(fa(6'h07, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] + ~rg[1] + 1);
		ex(fb(6'h0E, 5'd3, 5'd1, 16'h0005), 1'b1, 5'd3, rg[1] + 32'd6);
		ex(fa(6'h24, 5'd5, 5'd1, 5'd0, 11'h001), 1'b1, 5'd5, 32'hFFFF_FFF8);
		carry(1'b0);
		ex(fa(6'h06, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] + rg[1]);
		done("arith");
		ex(fa(6'h20, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[1] | rg[2]);
		ex(fa(6'h21, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[1] & rg[2]);
		ex(fa(6'h22, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[1] ^ rg[2]);
		ex(fa(6'h23, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[1] & ~rg[2]);
		ex(fa(6'h10, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, 32'hDCBA_9880);
		ex(fb(6'h18, 5'd3, 5'd1, 16'hFFFD), 1'b1, 5'd3, 32'h0000_0030);
		ex(fa(6'h11, 5'd3, 5'd1, 5'd4, 11'h000), 1'b1, 5'd3, 32'h0FFF_FFFF);
		ex(fa(6'h11, 5'd3, 5'd1, 5'd4, 11'h200), 1'b1, 5'd3, 32'hFFFF_FFFF);
		ex(fa(6'h11, 5'd3, 5'd1, 5'd4, 11'h400), 1'b1, 5'd3, 32'hFFFF_FF00);
		ex(fb(6'h19, 5'd3, 5'd2, 16'h0208), 1'b1, 5'd3, 32'h0012_3456);
		ex(fb(6'h19, 5'd3, 5'd2, 16'h0408), 1'b1, 5'd3, 32'h3456_7800);
		ex(fa(6'h12, 5'd3, 5'd4, 5'd1, 11'h000), 1'b1, 5'd3, 32'hFFFF_FFFC);
		ex(fa(6'h12, 5'd3, 5'd4, 5'd1, 11'h001), 1'b1, 5'd3, 32'h3FFF_FFFC);
		ex(fa(6'h24, 5'd3, 5'd7, 5'd0, 11'h060), 1'b1, 5'd3, 32'hFFFF_FF80);
		ex(fa(6'h24, 5'd3, 5'd7, 5'd0, 11'h061), 1'b1, 5'd3, 32'hFFFF_8080);
		ex(fa(6'h00, 5'd0, 5'd1, 5'd2, 11'h000), 1'b0, 5'd0, 32'h0);
		ex(fa(6'h00, 5'd3, 5'd0, 5'd2, 11'h000), 1'b1, 5'd3, rg[2]);
		done("datapath");
		stream_in_data = 32'hC0DE_0001;
		ex(fb(6'h1B, 5'd8, 5'd0, 16'h4002), 1'b1, 5'd8, 32'hC0DE_0001);
		chkb("stream_get", 1'b0, stream_get);
		carry(1'b1);
		stream_in_has_data = 1'b1;
		stream_in_ctrl_flag = 1'b1;
		ex(fb(6'h1B, 5'd8, 5'd0, 16'h0005), 1'b1, 5'd8, 32'hC0DE_0001);
		chkb("stream_get", 1'b1, stream_get);
		chk("port", 32'd5, {29'h0, stream_port_n});
		chkb("stream_bit", 1'b1, machine_status_word[srd_pkg::MSW_STREAM]);
		ex(fb(6'h1B, 5'd8, 5'd0, 16'h6005), 1'b1, 5'd8, 32'hC0DE_0001);
		chkb("stream_bit", 1'b0, machine_status_word[srd_pkg::MSW_STREAM]);
		carry(1'b0);
		stream_in_has_data = 1'b0;
		stream_in_ctrl_flag = 1'b0;
		fork
			ex(fb(6'h1B, 5'd8, 5'd0, 16'h0003), 1'b1, 5'd8, 32'hC0DE_0001);
			begin
				@(posedge clock);
				#2;
				chkb("get_stall", 1'b1, stall);
				@(posedge clock);
				#1;
				stream_in_has_data = 1'b1;
			end
		join
		chkb("stream_get", 1'b1, stream_get);
		stream_out_full = 1'b1;
		fork
			ex(fb(6'h1B, 5'd0, 5'd2, 16'h8001), 1'b0, 5'd0, 32'h0);
			begin
				@(posedge clock);
				#2;
				chkb("stall", 1'b1, stall);
				chkb("stream_put", 1'b0, stream_put);
				@(posedge clock);
				#1;
				stream_out_full = 1'b0;
			end
		join
		chkb("stream_put", 1'b1, stream_put);
		chk("put_data", rg[2], stream_out_data);
		stream_out_full = 1'b1;
		ex(fb(6'h1B, 5'd0, 5'd2, 16'hC001), 1'b0, 5'd0, 32'h0);
		chkb("stream_put", 1'b0, stream_put);
		carry(1'b1);
		stream_out_full = 1'b0;
		ex(fb(6'h1B, 5'd0, 5'd1, 16'hE001), 1'b0, 5'd0, 32'h0);
		chkb("stream_ctrl", 1'b1, stream_ctrl);
		carry(1'b0);
		done("stream");
		ex(fa(6'h24, 5'd1, 5'd1, 5'd2, 11'h068), 1'b0, 5'd0, 32'h0);
		chkb("icache", 1'b1, icache_line_write);
		chk("tag", rg[1], cache_tag);
		ex(fa(6'h24, 5'd2, 5'd2, 5'd1, 11'h064), 1'b0, 5'd0, 32'h0);
		chkb("dcache", 1'b1, dcache_line_write);
		chk("data", rg[1], cache_data);
		done("cache");
		pc = 32'h0000_0100;
		ex(fb(6'h25, 5'd9, 5'd0, 16'h8000), 1'b1, 5'd9, 32'h0000_0100);
		ex(fb(6'h25, 5'd9, 5'd0, 16'h8003), 1'b1, 5'd9, 32'h0000_0A00);
		ex(fb(6'h25, 5'd9, 5'd0, 16'h8005), 1'b1, 5'd9, 32'h0000_00E0);
		ex(fb(6'h25, 5'd0, 5'd1, 16'hC001), 1'b0, 5'd0, 32'h0);
		idle(0);
		chk("status_early", 32'h0, machine_status_word);
		idle(1);
		chk("status_late", 32'h7FFF_FFF0, machine_status_word);
		ex(fb(6'h25, 5'd9, 5'd0, 16'h8001), 1'b1, 5'd9, 32'h7FFF_FFF0);
		ex(fb(6'h25, 5'd10, 5'd1, 16'h3FF0), 1'b1, 5'd10, 32'h7FFF_FFF0);
		idle(2);
		ex(fb(6'h25, 5'd10, 5'd0, 16'h0004), 1'b1, 5'd10, 32'h7FFF_C000);
		idle(2);
		ex(fb(6'h25, 5'd9, 5'd0, 16'h8001), 1'b1, 5'd9, 32'hFFFF_C004);
		done("special");
		ex(fa(6'h26, 5'd0, 5'd0, 5'd4, 11'h000), 1'b0, 5'd0, 32'h0);
		chkb("redirect", 1'b1, redirect);
		chk("target", 32'h0000_0104, redirect_target);
		pc = 32'h0000_0200;
		ex(fa(6'h26, 5'd0, 5'h10, 5'd4, 11'h000), 1'b0, 5'd0, 32'h0);
		chkb("redirect", 1'b0, redirect);
		pc = 32'h0000_0204;
		ex(fa(6'h00, 5'd3, 5'd1, 5'd2, 11'h000), 1'b1, 5'd3, rg[2] + rg[1]);
		chkb("redirect", 1'b1, redirect);
		chk("target", 32'h0000_0204, redirect_target);
		done("branch");
		idle(2);
		finish_test();
	end
endmodule // test_srd_decode_exec
